// [common/pmc_pkg.sv]
// Shared constants and types for the modulator configuration and lock detector
package pmc_pkg;

   // Register addresses on the serial register port
   localparam logic [4:0] REG_INTG = 5'h03;
   localparam logic [4:0] REG_FRAC = 5'h04;
   localparam logic [4:0] REG_SD = 5'h06;
   localparam logic [4:0] REG_LD = 5'h07;
   localparam logic [4:0] REG_GPO = 5'h0f;
   localparam logic [4:0] REG_STAT = 5'h12;

   // Reset values
   localparam logic [18:0] INTG_RST = 19'h00019;
   localparam logic [23:0] FRAC_RST = 24'h000000;
   localparam logic [23:0] SD_RST = 24'h200b4a;
   localparam logic [23:0] LD_RST = 24'h00014d;
   localparam logic [23:0] GPO_RST = 24'h000001;

   // Modulator configuration fields
   localparam int SD_SEED_LSB = 0;
   localparam int SD_BYPASS_BIT = 7;
   localparam int SD_SEED_AUTOLOAD_BIT = 8;
   localparam int SD_CORE_EN_BIT = 11;

   // Seed codes and preset values
   localparam logic [1:0] SEED_ZERO = 2'h0;
   localparam logic [1:0] SEED_LSB = 2'h1;
   localparam logic [1:0] SEED_PRE_A = 2'h2;
   localparam logic [23:0] SEED_VAL_LSB = 24'h000001;
   localparam logic [23:0] SEED_VAL_A = 24'hb29d08;
   localparam logic [23:0] SEED_VAL_B = 24'h50f1cd;

   // Lock detect configuration fields
   localparam int LD_CNT_LSB = 0;
   localparam int LD_EN_BIT = 3;
   localparam int LD_WTYPE_BIT = 6;
   localparam int LD_DUR_LSB = 7;
   localparam int LD_FCLK_LSB = 10;

   // Output select fields and pin function codes
   localparam int GPO_SEL_LSB = 0;
   localparam int GPO_SHARE_BIT = 6;
   localparam logic [4:0] GPO_SEL_LOCK = 5'h01;
   localparam logic [4:0] GPO_SEL_LDCLK = 5'h02;
   localparam int STAT_LOCK_BIT = 1;

   // Analog window expressed in system clock cycles, rounded down, at least one
   localparam int CLK_PERIOD_NS = 40;
   localparam int ANA_WIN_NS = 10;
   localparam int ANA_WIN_CYC_I = (ANA_WIN_NS / CLK_PERIOD_NS) < 1 ? 1
                                  : (ANA_WIN_NS / CLK_PERIOD_NS);
   localparam logic [7:0] ANA_WIN_CYC = ANA_WIN_CYC_I[7:0];

   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [23:0] wdata;
   } pmc_reg_req_t;

   // Seed code to modulator start value
   function automatic logic [23:0] pmc_seed_value(input logic [1:0] code);
      case (code)
         SEED_ZERO: pmc_seed_value = 24'h000000;
         SEED_LSB: pmc_seed_value = SEED_VAL_LSB;
         SEED_PRE_A: pmc_seed_value = SEED_VAL_A;
         default: pmc_seed_value = SEED_VAL_B;
      endcase
   endfunction

   // Consecutive hit target per code
   function automatic logic [15:0] pmc_hit_target(input logic [2:0] code);
      case (code)
         3'h0: pmc_hit_target = 16'h0005;
         3'h1: pmc_hit_target = 16'h0020;
         3'h2: pmc_hit_target = 16'h0060;
         3'h3: pmc_hit_target = 16'h0100;
         3'h4: pmc_hit_target = 16'h0200;
         3'h5: pmc_hit_target = 16'h0800;
         3'h6: pmc_hit_target = 16'h2000;
         default: pmc_hit_target = 16'hffff;
      endcase
   endfunction

endpackage

// [rtl/pmc_ld_clk_div.sv]
// Divider that makes the internal lock-detect clock as half-period ticks
`timescale 1ns/1ns
module pmc_ld_clk_div
   import pmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic en,
   input wire logic [1:0] rate_code,
   // Outputs
   output logic half_tick,
   output logic ld_clk
);

   logic [3:0] cnt_reg, cnt_next;
   logic tick_reg, tick_next;
   logic clk_reg, clk_next;
   logic [3:0] last;

   // Half period is two to the power of the rate code system cycles
   always_comb
   begin
      last = 4'((4'h1 << rate_code) - 4'h1);
      cnt_next = cnt_reg;
      tick_next = 1'b0;
      clk_next = clk_reg;
      if (!en)
      begin
         cnt_next = 4'h0;
         clk_next = 1'b0;
      end
      else if (cnt_reg >= last)
      begin
         cnt_next = 4'h0;
         tick_next = 1'b1;
         clk_next = ~clk_reg;
      end
      else
      begin
         cnt_next = cnt_reg + 4'h1;
      end
   end

   // State registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_reg <= 4'h0;
         tick_reg <= 1'b0;
         clk_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
         clk_reg <= clk_next;
      end
   end

   assign half_tick = tick_reg;
   assign ld_clk = clk_reg;

endmodule // pmc_ld_clk_div

// [rtl/pmc_hit_count.sv]
// Consecutive in-window hit counter and lock flag
`timescale 1ns/1ns
module pmc_hit_count
   import pmc_pkg::*;
#(
   parameter int CW = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Events
   input wire logic en,
   input wire logic hit,
   input wire logic miss,
   input wire logic [CW-1:0] target,
   // Outputs
   output logic locked
);

   logic [CW-1:0] cnt_reg, cnt_next;
   logic lock_reg, lock_next;

   // A miss restarts the run; hold once the target is reached
   always_comb
   begin
      cnt_next = cnt_reg;
      lock_next = lock_reg;
      if (!en || miss)
      begin
         cnt_next = '0;
         lock_next = 1'b0;
      end
      else if (hit)
      begin
         if (cnt_reg < target)
         begin
            cnt_next = cnt_reg + 1'b1;
         end
         if (cnt_next >= target)
         begin
            lock_next = 1'b1;
         end
      end
   end

   // State registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_reg <= '0;
         lock_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         lock_reg <= lock_next;
      end
   end

   assign locked = lock_reg;

endmodule // pmc_hit_count

// [rtl/pmc_top.sv]
// Modulator configuration, calibration trigger and lock detector
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: seed code picks zero, lsb or preset
// RULE2: seed loads only on frequency change with autoload
// RULE3: bypass bit removes modulator from divider path
// RULE4: bypassed modulator still steps when released
// RULE5: core enable bit switches fractional core
// RULE6: core enable picks which write starts calibration
// RULE7: lock detect enable gates all detection
// RULE8: only arrival difference magnitude matters
// RULE9: lock after target consecutive in-window edges
// RULE10: window type zero uses fixed short window
// RULE11: host avoids analog window at high rates
// RULE12: window type one uses counted clock cycles
// RULE13: lock-detect clock rate set by field
// RULE14: lock-detect clock observable on test pin
// RULE15: lock flag readable in status register
// RULE16: select value one drives lock on pin
// RULE17: pin carries serial data during reads
// RULE18: target codes give 5 up to 65535
// RULE19: duration codes give half to 64 cycles
// RULE20: out-of-window pair restarts count, drops lock
module pmc_top
   import pmc_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_B,
   // Register port from the serial interface
   input wire pmc_reg_req_t REG_REQ,
   output logic [23:0] REG_RDATA,
   output logic REG_RVALID,
   // Phase detector events
   input wire logic REF_EDGE,
   input wire logic VCO_EDGE,
   input wire logic PFD_TICK,
   input wire logic MOD_RST_B,
   // Serial read in progress
   input wire logic SPI_READ_ACTIVE,
   input wire logic SPI_SDO,
   // Divider and calibration
   output logic [18:0] DIV_N,
   output logic VCO_CAL_START,
   // Lock outputs
   output logic LOCK_DETECT,
   output logic LOCK_PIN,
   output logic LOCK_PIN_OE
);

   typedef enum {LD_IDLE, LD_REF_FIRST, LD_VCO_FIRST} pmc_ld_state_t;

   logic [18:0] intg_reg, intg_next;
   logic [23:0] frac_reg, frac_next;
   logic [23:0] sd_reg, sd_next;
   logic [23:0] ld_reg, ld_next;
   logic [23:0] gpo_reg, gpo_next;
   logic [23:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic [23:0] acc_reg, acc_next;
   logic carry_reg, carry_next;
   logic [18:0] div_reg, div_next;
   logic cal_reg, cal_next;
   logic pin_reg, pin_next;
   logic oe_reg;
   pmc_ld_state_t st_reg, st_next;
   logic [7:0] el_reg, el_next;
   logic hit_reg, hit_next;
   logic miss_reg, miss_next;
   logic core_en, bypass, seed_autoload, ld_en, wtype, cal_fire, step;
   logic [24:0] sum;
   logic [7:0] win;
   logic inc, half_tick, ld_clk, locked;

   // Configuration decode
   assign core_en = sd_reg[SD_CORE_EN_BIT];
   assign bypass = sd_reg[SD_BYPASS_BIT];
   assign seed_autoload = sd_reg[SD_SEED_AUTOLOAD_BIT];
   assign ld_en = ld_reg[LD_EN_BIT];
   assign wtype = ld_reg[LD_WTYPE_BIT];

   // Calibration start write depends on core state before the write
   assign cal_fire = REG_REQ.wr && (core_en ? (REG_REQ.addr == REG_FRAC)
                                            : (REG_REQ.addr == REG_INTG)); // [RULE6]

   // Register writes and registered read answer
   always_comb
   begin
      intg_next = intg_reg;
      frac_next = frac_reg;
      sd_next = sd_reg;
      ld_next = ld_reg;
      gpo_next = gpo_reg;
      rdata_next = rdata_reg;
      rvalid_next = REG_REQ.rd;
      if (REG_REQ.wr)
      begin
         case (REG_REQ.addr)
            REG_INTG: intg_next = REG_REQ.wdata[18:0];
            REG_FRAC: frac_next = REG_REQ.wdata;
            REG_SD: sd_next = REG_REQ.wdata; // Seed code waits here as a shadow [RULE2]
            REG_LD: ld_next = REG_REQ.wdata;
            REG_GPO: gpo_next = REG_REQ.wdata;
            default: ;
         endcase
      end
      if (REG_REQ.rd)
      begin
         case (REG_REQ.addr)
            REG_INTG: rdata_next = {5'h00, intg_reg};
            REG_FRAC: rdata_next = frac_reg;
            REG_SD: rdata_next = sd_reg;
            REG_LD: rdata_next = ld_reg;
            REG_GPO: rdata_next = gpo_reg;
            REG_STAT: rdata_next = 24'(locked) << STAT_LOCK_BIT; // [RULE15]
            default: rdata_next = 24'h000000;
         endcase
      end
   end

   // Modulator keeps stepping under bypass so isolation can be tested
   assign step = core_en && MOD_RST_B && PFD_TICK; // [RULE4] [RULE5]
   assign sum = {1'b0, acc_reg} + {1'b0, frac_reg};

   always_comb
   begin
      acc_next = acc_reg;
      carry_next = 1'b0;
      if (!MOD_RST_B)
      begin
         acc_next = 24'h000000;
      end
      else if (cal_fire && seed_autoload)
      begin
         acc_next = pmc_seed_value(sd_reg[SD_SEED_LSB +: 2]); // [RULE1] [RULE2]
      end
      else if (step)
      begin
         acc_next = sum[23:0];
         carry_next = sum[24];
      end
      // Modulator carry is ignored while bypassed
      div_next = bypass ? intg_reg : 19'(intg_reg + 19'(carry_reg)); // [RULE3]
   end

   // Window length: analog short window or counted half periods
   assign win = wtype ? 8'(8'h01 << ld_reg[LD_DUR_LSB +: 3]) : ANA_WIN_CYC; // [RULE10] [RULE12] [RULE19]
   assign inc = wtype ? half_tick : 1'b1;

   // Arrival difference: symmetric states, either edge may lead
   always_comb
   begin
      st_next = st_reg;
      el_next = el_reg;
      hit_next = 1'b0;
      miss_next = 1'b0;
      if (!ld_en)
      begin
         st_next = LD_IDLE; // [RULE7]
         el_next = 8'h00;
      end
      else
      begin
         case (st_reg)
            LD_IDLE:
            begin
               el_next = 8'h00;
               if (REF_EDGE && VCO_EDGE)
               begin
                  hit_next = 1'b1;
               end
               else if (REF_EDGE)
               begin
                  st_next = LD_REF_FIRST;
               end
               else if (VCO_EDGE)
               begin
                  st_next = LD_VCO_FIRST;
               end
            end
            LD_REF_FIRST, LD_VCO_FIRST:
            begin
               if (inc && el_reg != 8'hff)
               begin
                  el_next = el_reg + 8'h01;
               end
               if ((st_reg == LD_REF_FIRST) ? VCO_EDGE : REF_EDGE)
               begin
                  hit_next = (el_reg < win); // [RULE8]
                  miss_next = !(el_reg < win); // [RULE20]
                  st_next = LD_IDLE;
               end
               else if ((st_reg == LD_REF_FIRST) ? REF_EDGE : VCO_EDGE)
               begin
                  miss_next = 1'b1; // Lead edge repeated without partner
                  el_next = 8'h00;
               end
            end
            default: st_next = LD_IDLE;
         endcase
      end
   end

   // Shared pin: serial data wins during reads when sharing
   always_comb
   begin
      if (!gpo_reg[GPO_SHARE_BIT] && SPI_READ_ACTIVE)
      begin
         pin_next = SPI_SDO; // [RULE17]
      end
      else if (gpo_reg[GPO_SEL_LSB +: 5] == GPO_SEL_LOCK)
      begin
         pin_next = locked; // [RULE16]
      end
      else if (gpo_reg[GPO_SEL_LSB +: 5] == GPO_SEL_LDCLK)
      begin
         pin_next = ld_clk; // [RULE14]
      end
      else
      begin
         pin_next = 1'b0;
      end
      cal_next = cal_fire;
   end

   // State registers
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         intg_reg <= INTG_RST;
         frac_reg <= FRAC_RST;
         sd_reg <= SD_RST;
         ld_reg <= LD_RST;
         gpo_reg <= GPO_RST;
         rdata_reg <= 24'h000000;
         rvalid_reg <= 1'b0;
         acc_reg <= 24'h000000;
         carry_reg <= 1'b0;
         div_reg <= INTG_RST;
         cal_reg <= 1'b0;
         pin_reg <= 1'b0;
         oe_reg <= 1'b0;
         st_reg <= LD_IDLE;
         el_reg <= 8'h00;
         hit_reg <= 1'b0;
         miss_reg <= 1'b0;
      end
      else
      begin
         intg_reg <= intg_next;
         frac_reg <= frac_next;
         sd_reg <= sd_next;
         ld_reg <= ld_next;
         gpo_reg <= gpo_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         acc_reg <= acc_next;
         carry_reg <= carry_next;
         div_reg <= div_next;
         cal_reg <= cal_next;
         pin_reg <= pin_next;
         oe_reg <= 1'b1;
         st_reg <= st_next;
         el_reg <= el_next;
         hit_reg <= hit_next;
         miss_reg <= miss_next;
      end
   end

   // Lock-detect clock divider
   pmc_ld_clk_div u_div (
      .clk(CLOCK),
      .rst_b(RST_B),
      .en(ld_en),
      .rate_code(ld_reg[LD_FCLK_LSB +: 2]), // [RULE13]
      .half_tick(half_tick),
      .ld_clk(ld_clk)
   );

   // Consecutive hit counter
   pmc_hit_count #(.CW(16)) u_cnt (
      .clk(CLOCK),
      .rst_b(RST_B),
      .en(ld_en),
      .hit(hit_reg),
      .miss(miss_reg),
      .target(pmc_hit_target(ld_reg[LD_CNT_LSB +: 3])), // [RULE9] [RULE18]
      .locked(locked)
   );

   assign REG_RDATA = rdata_reg;
   assign REG_RVALID = rvalid_reg;
   assign DIV_N = div_reg;
   assign VCO_CAL_START = cal_reg;
   assign LOCK_DETECT = locked;
   assign LOCK_PIN = pin_reg;
   assign LOCK_PIN_OE = oe_reg;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_B);

   sequence s_frac_write;
      REG_REQ.wr && REG_REQ.addr == REG_FRAC;
   endsequence
   sequence s_int_write;
      REG_REQ.wr && REG_REQ.addr == REG_INTG;
   endsequence

   a_cal_frac_start: assert property (s_frac_write and core_en |=> VCO_CAL_START) // [RULE6]
      else $error("fractional write did not start calibration");
   a_cal_int_start: assert property (s_int_write and !core_en |=> VCO_CAL_START) // [RULE6]
      else $error("integer write did not start calibration");
   a_seed_load: assert property (cal_fire && seed_autoload && MOD_RST_B
      |=> acc_reg == pmc_seed_value($past(sd_reg[1:0]))) // [RULE2]
      else $error("seed not loaded on frequency change");
   a_seed_held: assert property (!cal_fire && !step && MOD_RST_B |=> $stable(acc_reg)) // [RULE2]
      else $error("modulator state moved without cause");
   a_bypass_path: assert property (bypass && $stable(intg_reg) ##1 bypass
      |=> DIV_N == $past(intg_reg)) // [RULE3]
      else $error("bypassed divider not integer");
   a_bypass_clocked: assert property (step && bypass && !cal_fire
      |=> acc_reg == 24'($past(acc_reg) + $past(frac_reg))) // [RULE4]
      else $error("bypassed modulator not stepping");
   a_core_off: assert property (!core_en && !cal_fire && MOD_RST_B |=> $stable(acc_reg)) // [RULE5]
      else $error("disabled core stepped");
   a_ld_disabled: assert property (!ld_en ##1 !ld_en |=> !LOCK_DETECT && !hit_reg) // [RULE7]
      else $error("lock activity while disabled");
   a_miss_drops: assert property (miss_reg |=> !LOCK_DETECT) // [RULE20]
      else $error("miss did not drop lock");
   a_stat_read: assert property (REG_REQ.rd && REG_REQ.addr == REG_STAT
      |=> REG_RVALID && REG_RDATA[STAT_LOCK_BIT] == $past(locked)) // [RULE15]
      else $error("status lock bit wrong");
   a_pin_lock: assert property (gpo_reg[4:0] == GPO_SEL_LOCK && gpo_reg[GPO_SHARE_BIT]
      |=> LOCK_PIN == $past(locked)) // [RULE16]
      else $error("pin does not show lock");
   a_pin_sdo: assert property (!gpo_reg[GPO_SHARE_BIT] && SPI_READ_ACTIVE
      |=> LOCK_PIN == $past(SPI_SDO)) // [RULE17]
      else $error("pin does not carry serial data");

endmodule // pmc_top

// [sim/pmc_host_model.sv]
// Host controller model on the serial register port
`timescale 1ns/1ns
module pmc_host_model
   import pmc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output pmc_reg_req_t req,
   input wire logic [23:0] rdata,
   input wire logic rvalid,
   // Serial read state and shared pin
   output logic rd_active,
   output logic sdo,
   input wire logic pin
);
   logic sdo_bit;
   logic idle_pat = 1'b0;

   // Quiet start; no request before reset is gone
   initial
   begin
      req = '0;
      rd_active = 1'b0;
      sdo_bit = 1'b0;
   end

   // Idle data line wanders so a stale level can never pass for data
   always @(negedge clk)
      idle_pat <= ~idle_pat;
   assign sdo = rd_active ? sdo_bit : idle_pat;

   // Write: one-cycle pulse, fields scrambled once released
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      @(negedge clk);
      req = {1'b1, 1'b0, a, d};
      @(negedge clk);
      req = {1'b0, 1'b0, ~a, ~d};
   endtask

   // Read: serial read active over the request; answer and pin taken a cycle later
   task automatic rd(input logic [4:0] a, input logic bitv, output logic [23:0] d,
                     output logic ok, output logic pin_seen);
      @(negedge clk);
      req = {1'b0, 1'b1, a, 24'h000000};
      rd_active = 1'b1;
      sdo_bit = bitv;
      @(negedge clk);
      d = rdata;
      ok = rvalid;
      pin_seen = pin;
      req = {1'b0, 1'b0, ~a, 24'hffffff};
      rd_active = 1'b0;
   endtask
endmodule // pmc_host_model

// [sim/pmc_top_tb.sv]
// Self-checking bench for the modulator configuration and lock detector
`timescale 1ns/1ns
`define CHK(nm, e, g) \
   begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module pmc_top_tb
   import pmc_pkg::*;
;
   typedef struct packed {
      logic [4:0] addr;
      logic [23:0] exp;
   } pmc_row_t;
   logic CLOCK, RST_B, REG_RVALID, REF_EDGE, VCO_EDGE, PFD_TICK, MOD_RST_B;
   logic SPI_READ_ACTIVE, SPI_SDO, VCO_CAL_START, LOCK_DETECT, LOCK_PIN, LOCK_PIN_OE;
   pmc_reg_req_t REG_REQ;
   logic [23:0] REG_RDATA;
   logic [18:0] DIV_N;
   int num_errors = 0;
   int compares = 0;
   logic [23:0] d, sv, f;
   logic [24:0] sum;
   logic ok, pin, saw, prev;
   int tr;
   // Reset values, with one unmapped address that must read zero
   pmc_row_t rows [7] = '{'{REG_INTG, 24'h000019}, '{REG_FRAC, 24'h000000},
      '{REG_SD, 24'h200b4a}, '{REG_LD, 24'h00014d}, '{REG_GPO, 24'h000001},
      '{REG_STAT, 24'h000000}, '{5'h01, 24'h000000}};

   pmc_top dut (.CLOCK(CLOCK), .RST_B(RST_B), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
      .REG_RVALID(REG_RVALID), .REF_EDGE(REF_EDGE), .VCO_EDGE(VCO_EDGE),
      .PFD_TICK(PFD_TICK), .MOD_RST_B(MOD_RST_B), .SPI_READ_ACTIVE(SPI_READ_ACTIVE),
      .SPI_SDO(SPI_SDO), .DIV_N(DIV_N), .VCO_CAL_START(VCO_CAL_START),
      .LOCK_DETECT(LOCK_DETECT), .LOCK_PIN(LOCK_PIN), .LOCK_PIN_OE(LOCK_PIN_OE));

   pmc_host_model host (.clk(CLOCK), .req(REG_REQ), .rdata(REG_RDATA), .rvalid(REG_RVALID),
      .rd_active(SPI_READ_ACTIVE), .sdo(SPI_SDO), .pin(LOCK_PIN));

   // 25 MHz clock
   initial
   begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end

   // Closing report and verdict
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Edge pair: leading edge, then the other one gap cycles later
   task automatic pair(input logic lead, input int gap);
      @(negedge CLOCK);
      if (lead) VCO_EDGE = 1'b1; else REF_EDGE = 1'b1;
      @(negedge CLOCK);
      REF_EDGE = 1'b0;
      VCO_EDGE = 1'b0;
      repeat (gap - 1) @(negedge CLOCK);
      if (lead) REF_EDGE = 1'b1; else VCO_EDGE = 1'b1;
      @(negedge CLOCK);
      REF_EDGE = 1'b0;
      VCO_EDGE = 1'b0;
      repeat (3) @(negedge CLOCK);
   endtask

   // Modulator accumulator cleared by a short reset pulse
   task automatic clr();
      @(negedge CLOCK);
      MOD_RST_B = 1'b0;
      @(negedge CLOCK);
      MOD_RST_B = 1'b1;
   endtask

   // One modulator step; reports whether DIV_N showed a carry
   task automatic tick(output logic plus);
      @(negedge CLOCK);
      PFD_TICK = 1'b1;
      plus = 1'b0;
      @(negedge CLOCK);
      PFD_TICK = 1'b0;
      repeat (4)
      begin
         @(negedge CLOCK);
         plus = plus | (DIV_N === 19'h00101);
      end
   endtask

   // Watchdog, well beyond the few hundred cycles the run needs
   initial
   begin
      repeat (20000) @(posedge CLOCK);
      num_errors++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      RST_B = 1'b0;
      REF_EDGE = 1'b0;
      VCO_EDGE = 1'b0;
      PFD_TICK = 1'b0;
      MOD_RST_B = 1'b1;
      repeat (5) @(negedge CLOCK);
      `CHK("div_reset", 19'h00019, DIV_N)
      `CHK("oe_reset", 1'b0, LOCK_PIN_OE)
      RST_B = 1'b1;
      @(negedge CLOCK);
      `CHK("oe", 1'b1, LOCK_PIN_OE)
      foreach (rows[i])
      begin
         host.rd(rows[i].addr, 1'b0, d, ok, pin);
         `CHK("rvalid", 1'b1, ok)
         `CHK("reset_value", rows[i].exp, d)
      end
      // Analog window, five hits; phase detector rate assumed low
      host.wr(REG_LD, 24'h000008);
      for (int i = 0; i < 4; i++) pair(i[0], 1);
      `CHK("lock_early", 1'b0, LOCK_DETECT)
      pair(1'b1, 1);
      `CHK("lock", 1'b1, LOCK_DETECT)
      `CHK("pin_lock", 1'b1, LOCK_PIN)
      host.rd(REG_STAT, 1'b0, d, ok, pin);
      `CHK("stat_lock", 1'b1, d[STAT_LOCK_BIT])
      `CHK("pin_in_read", 1'b0, pin)
      @(negedge CLOCK);
      `CHK("pin_after_read", 1'b1, LOCK_PIN)
      host.wr(REG_GPO, 24'h000041);
      host.rd(REG_STAT, 1'b0, d, ok, pin);
      `CHK("pin_dedicated", 1'b1, pin)
      pair(1'b0, 2);
      `CHK("miss_analog", 1'b0, LOCK_DETECT)
      host.wr(REG_LD, 24'h000000);
      for (int i = 0; i < 6; i++) pair(1'b0, 1);
      `CHK("disabled", 1'b0, LOCK_DETECT)
      // Digital window of four half periods
      host.wr(REG_LD, 24'h000148);
      for (int i = 0; i < 5; i++) pair(i[0], 3);
      `CHK("lock_digital", 1'b1, LOCK_DETECT)
      pair(1'b0, 6);
      `CHK("miss_digital", 1'b0, LOCK_DETECT)
      // Lock-detect clock on the pin at two rates
      host.wr(REG_GPO, 24'h000002);
      for (int c = 0; c < 2; c++)
      begin
         host.wr(REG_LD, c ? 24'h000548 : 24'h000148);
         repeat (4) @(negedge CLOCK);
         tr = 0;
         prev = LOCK_PIN;
         repeat (32)
         begin
            @(negedge CLOCK);
            tr += (LOCK_PIN !== prev);
            prev = LOCK_PIN;
         end
         `CHK("ldclk_edges", c ? 16 : 32, tr)
      end
      // Seeds loaded by the frequency change, seen as a first-step carry
      // Integer write starts no calibration while the core is on
      host.wr(REG_INTG, 24'h000100);
      `CHK("cal_intg", 1'b0, VCO_CAL_START)
      for (int k = 0; k < 8; k++)
      begin
         case (k[1:0])
            2'h0: sv = 24'h000000;
            2'h1: sv = SEED_VAL_LSB;
            2'h2: sv = SEED_VAL_A;
            default: sv = SEED_VAL_B;
         endcase
         f = k[2] ? 24'hffffff : 24'h800000;
         sum = {1'b0, sv} + {1'b0, f};
         clr();
         host.wr(REG_SD, 24'h200b48 | {22'h0, k[1:0]});
         host.wr(REG_FRAC, f);
         `CHK("cal_frac", 1'b1, VCO_CAL_START)
         tick(saw);
         `CHK("seed_carry", sum[24], saw)
      end
      // Bypass hides the carry but the accumulator keeps stepping
      clr();
      host.wr(REG_SD, 24'h200bc9);
      host.wr(REG_FRAC, 24'hffffff);
      tick(saw);
      `CHK("bypass", 1'b0, saw)
      host.wr(REG_SD, 24'h200b49);
      tick(saw);
      `CHK("bypass_steps", 1'b0, saw)
      // Seed stays in its shadow without autoload or a frequency change
      clr();
      host.wr(REG_SD, 24'h200a4a);
      host.wr(REG_FRAC, 24'h800000);
      tick(saw);
      `CHK("no_autoload", 1'b0, saw)
      clr();
      host.wr(REG_SD, 24'h200b4a);
      tick(saw);
      `CHK("seed_held", 1'b0, saw)
      // Core off: integer write calibrates, no stepping
      host.wr(REG_SD, 24'h200349);
      host.wr(REG_FRAC, 24'hffffff);
      `CHK("cal_off_frac", 1'b0, VCO_CAL_START)
      host.wr(REG_INTG, 24'h000100);
      `CHK("cal_off_intg", 1'b1, VCO_CAL_START)
      tick(saw);
      `CHK("core_off", 1'b0, saw)
      give_verdict();
   end
endmodule // pmc_top_tb
